// file: sdram_command_decoder.sv
// top of the command decoder: bank, power and mode state with termination control
`timescale 1ns/100ps
// Operation
// RULE1: masked write beats are discarded
// RULE2: two data beats per strobe cycle, byte maskable
// RULE3: termination enable applies on-die termination
// RULE4: table one bit 11 makes mask a strobe
// RULE5: ignore termination enable when termination disabled
// RULE6: active low pin reset acts asynchronously; only the link front does, the system side takes it through two flops
// RULE7: controller activates idle banks, accesses active ones
// RULE8: decode write from strobe pattern
// RULE9: decode read from strobe pattern
// RULE10: chop bit low gives four-beat burst
// RULE11: precharge flag closes bank after access
// RULE12: all strobes low loads mode table
// RULE13: refresh code with gating picks auto/self
// RULE14: gating falling on idle code enters power down
// RULE15: gating rising on idle code exits low power
// RULE16: mask input enables masking while bank active
// RULE17: chip select high means deselect
// RULE18: chop bit counts only when on-the-fly enabled
// RULE19: precharge flag high closes all banks
// RULE20: illegal commands ignored, state unchanged
module sdram_command_decoder #(
  parameter int NUM_BANKS = sdram_cmd_pkg::NUM_BANKS,
  parameter int DATA_W = sdram_cmd_pkg::DATA_W
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ck_link,
  input wire logic reset_n,
  input wire logic chip_select_n,
  input wire logic row_strobe_n,
  input wire logic col_strobe_n,
  input wire logic write_select_n,
  input wire logic clock_gate,
  input wire logic [sdram_cmd_pkg::BANK_W-1:0] bank_select,
  input wire logic [sdram_cmd_pkg::ADDR_W-1:0] addr,
  input wire logic termination_enable,
  input wire logic [DATA_W-1:0] data_lines_rise,
  input wire logic [DATA_W-1:0] data_lines_fall,
  input wire logic write_byte_mask_rise,
  input wire logic write_byte_mask_fall,
  input wire logic data_beat_valid,
  output sdram_cmd_pkg::cmd_t cmd_code,
  output logic cmd_strobe,
  output logic cmd_reject,
  output logic [sdram_cmd_pkg::BANK_W-1:0] access_bank,
  output logic [sdram_cmd_pkg::COL_W-1:0] access_col,
  output logic access_full_burst,
  output logic access_auto_precharge,
  output logic [NUM_BANKS-1:0] bank_open,
  output sdram_cmd_pkg::power_t power_mode,
  output logic term_data_on,
  output logic term_strobe_on,
  output logic termination_strobe_mode,
  output logic [2*DATA_W-1:0] wr_data,
  output logic [1:0] wr_keep,
  output logic wr_strobe
);
  typedef struct packed {
    logic rstn_s1;
    logic rstn_s2;
    logic odt_s1;
    logic odt_s2;
    sdram_cmd_pkg::power_t power;
    logic [NUM_BANKS-1:0] open;
    logic [sdram_cmd_pkg::MODE_TABLES-1:0][sdram_cmd_pkg::ADDR_W-1:0] mode_tab;
    sdram_cmd_pkg::cmd_t code;
    logic strobe;
    logic reject;
    logic [sdram_cmd_pkg::BANK_W-1:0] bank;
    logic [sdram_cmd_pkg::COL_W-1:0] col;
    logic full_burst;
    logic auto_pre;
    logic term_data;
    logic term_strobe;
    logic strobe_mode;
    logic mask_allow;
    logic [2*DATA_W-1:0] wdata;
    logic [1:0] keep;
    logic wvalid;
  } top_state_t;

  localparam top_state_t TOP_RESET = '{
    rstn_s1: 1'b0, rstn_s2: 1'b0, odt_s1: 1'b0, odt_s2: 1'b0,
    power: sdram_cmd_pkg::PWR_RUN, open: '0, mode_tab: '0,
    code: sdram_cmd_pkg::CMD_NONE, strobe: 1'b0, reject: 1'b0, bank: '0, col: '0,
    full_burst: 1'b1, auto_pre: 1'b0, term_data: 1'b0, term_strobe: 1'b0,
    strobe_mode: 1'b0, mask_allow: 1'b1, wdata: '0, keep: 2'h0, wvalid: 1'b0};

  top_state_t st_reg;
  top_state_t st_next;
  sdram_cmd_pkg::evt_t ev;
  logic ev_valid;
  logic sys_rst;
  logic [sdram_cmd_pkg::ADDR_W-1:0] mode_zero;
  logic [sdram_cmd_pkg::ADDR_W-1:0] mode_one;
  logic [sdram_cmd_pkg::ADDR_W-1:0] mode_two;
  logic bank_is_open;
  logic all_idle;
  logic legal;

  // one-hot select of a bank
  function automatic logic [NUM_BANKS-1:0] bank_hot(input logic [sdram_cmd_pkg::BANK_W-1:0] b);
    logic [NUM_BANKS-1:0] h;
    h = '0;
    h[b] = 1'b1;
    return h;
  endfunction

  // true when any termination value is programmed in tables one or two
  function automatic logic rtt_enabled(input logic [sdram_cmd_pkg::ADDR_W-1:0] m1,
                                       input logic [sdram_cmd_pkg::ADDR_W-1:0] m2);
    return m1[sdram_cmd_pkg::RTT_NOM_POS0] || m1[sdram_cmd_pkg::RTT_NOM_POS1]
        || m1[sdram_cmd_pkg::RTT_NOM_POS2]
        || (m2[sdram_cmd_pkg::RTT_WR_HI:sdram_cmd_pkg::RTT_WR_LO] != 2'h0);
  endfunction

  sdram_evt_if evt_bus ();

  // system side is held while the pin reset, seen through two flops, is low
  assign sys_rst = srst || !st_reg.rstn_s2; // RULE6
  assign evt_bus.mask_allow = st_reg.mask_allow;

  sdram_link_front u_front (
    .ck_link(ck_link),
    .reset_n(reset_n),
    .chip_select_n(chip_select_n),
    .row_strobe_n(row_strobe_n),
    .col_strobe_n(col_strobe_n),
    .write_select_n(write_select_n),
    .clock_gate(clock_gate),
    .bank_select(bank_select),
    .addr(addr),
    .data_lines_rise(data_lines_rise),
    .data_lines_fall(data_lines_fall),
    .write_byte_mask_rise(write_byte_mask_rise),
    .write_byte_mask_fall(write_byte_mask_fall),
    .data_beat_valid(data_beat_valid),
    .evt(evt_bus.src)
  );

  sdram_evt_sync u_sync (
    .clk_sys(clk_sys),
    .rst(sys_rst),
    .evt(evt_bus.dst),
    .evt_word(ev),
    .evt_valid(ev_valid)
  );

  // mode table views and bank status of the addressed bank
  always_comb
  begin
    mode_zero = st_reg.mode_tab[sdram_cmd_pkg::MODE_ZERO_SEL];
    mode_one = st_reg.mode_tab[sdram_cmd_pkg::MODE_ONE_SEL];
    mode_two = st_reg.mode_tab[sdram_cmd_pkg::MODE_TWO_SEL];
    bank_is_open = |(st_reg.open & bank_hot(ev.bank));
    all_idle = st_reg.open == sdram_cmd_pkg::BANKS_IDLE;
  end

  // legality of each command against bank and power state
  always_comb
  begin
    legal = 1'b0;
    if (st_reg.power == sdram_cmd_pkg::PWR_RUN)
    begin
      unique case (ev.cmd)
        sdram_cmd_pkg::CMD_ACT: legal = !bank_is_open; // RULE7 RULE20
        sdram_cmd_pkg::CMD_RD,
        sdram_cmd_pkg::CMD_WR: legal = bank_is_open; // RULE7 RULE20
        sdram_cmd_pkg::CMD_MRS,
        sdram_cmd_pkg::CMD_REF,
        sdram_cmd_pkg::CMD_SREF_IN,
        sdram_cmd_pkg::CMD_ZQ: legal = all_idle; // RULE12 RULE20
        sdram_cmd_pkg::CMD_PRE,
        sdram_cmd_pkg::CMD_PDOWN_IN: legal = 1'b1;
        default: legal = 1'b0;
      endcase
    end
    else
      legal = ev.cmd == sdram_cmd_pkg::CMD_LOW_EXIT; // RULE15 RULE20
  end

  // main next-state logic
  always_comb
  begin
    st_next = st_reg;
    st_next.rstn_s1 = reset_n;
    st_next.rstn_s2 = st_reg.rstn_s1;
    st_next.odt_s1 = termination_enable;
    st_next.odt_s2 = st_reg.odt_s1;
    st_next.strobe = 1'b0;
    st_next.reject = 1'b0;
    st_next.wvalid = 1'b0;

    // termination, strobe mode and mask permission follow the mode tables
    st_next.strobe_mode = mode_one[sdram_cmd_pkg::TERM_STROBE_POS]; // RULE4
    st_next.mask_allow = !mode_one[sdram_cmd_pkg::TERM_STROBE_POS]; // RULE4 RULE16
    st_next.term_data = st_reg.odt_s2 && rtt_enabled(mode_one, mode_two); // RULE3 RULE5
    st_next.term_strobe = st_reg.odt_s2 && rtt_enabled(mode_one, mode_two)
        && mode_one[sdram_cmd_pkg::TERM_STROBE_POS]; // RULE3 RULE4 RULE5

    if (ev_valid)
    begin
      // write beats pass on only while a bank is open
      if (ev.wvalid && st_reg.open != sdram_cmd_pkg::BANKS_IDLE)
      begin
        st_next.wdata = ev.wdata; // RULE2
        st_next.keep = ev.keep; // RULE1
        st_next.wvalid = 1'b1;
      end

      if (ev.cmd != sdram_cmd_pkg::CMD_NONE)
      begin
        st_next.code = ev.cmd;
        st_next.bank = ev.bank;
        st_next.strobe = legal;
        st_next.reject = !legal; // RULE20
      end

      if (ev.cmd != sdram_cmd_pkg::CMD_NONE && legal)
      begin
        unique case (ev.cmd)
          sdram_cmd_pkg::CMD_ACT:
            st_next.open = st_reg.open | bank_hot(ev.bank);
          sdram_cmd_pkg::CMD_PRE:
          begin
            if (ev.addr[sdram_cmd_pkg::PRE_FLAG_POS])
              st_next.open = sdram_cmd_pkg::BANKS_IDLE; // RULE19
            else
              st_next.open = st_reg.open & ~bank_hot(ev.bank); // RULE19
          end
          sdram_cmd_pkg::CMD_RD,
          sdram_cmd_pkg::CMD_WR:
          begin
            st_next.col = ev.addr[sdram_cmd_pkg::COL_W-1:0];
            st_next.auto_pre = ev.addr[sdram_cmd_pkg::PRE_FLAG_POS]; // RULE11
            if (ev.addr[sdram_cmd_pkg::PRE_FLAG_POS])
              st_next.open = st_reg.open & ~bank_hot(ev.bank); // RULE11
            unique case (mode_zero[sdram_cmd_pkg::BURST_FIELD_LO +: 2])
              sdram_cmd_pkg::BURST_ON_FLY:
                st_next.full_burst = ev.addr[sdram_cmd_pkg::CHOP_POS]; // RULE10 RULE18
              sdram_cmd_pkg::BURST_FIXED4:
                st_next.full_burst = 1'b0; // RULE18
              default:
                st_next.full_burst = 1'b1; // RULE18
            endcase
          end
          sdram_cmd_pkg::CMD_MRS:
            st_next.mode_tab[ev.bank[sdram_cmd_pkg::MODE_SEL_W-1:0]] = ev.addr; // RULE12
          sdram_cmd_pkg::CMD_SREF_IN:
            st_next.power = sdram_cmd_pkg::PWR_SELF; // RULE13
          sdram_cmd_pkg::CMD_PDOWN_IN:
            st_next.power = sdram_cmd_pkg::PWR_DOWN; // RULE14
          sdram_cmd_pkg::CMD_LOW_EXIT:
            st_next.power = sdram_cmd_pkg::PWR_RUN; // RULE15
          default:
            st_next.power = st_reg.power;
        endcase
      end
    end

    // pin reset clears all but its own synchroniser and the termination enable synchroniser
    if (!st_reg.rstn_s2)
    begin
      st_next = TOP_RESET;
      st_next.rstn_s1 = reset_n;
      st_next.rstn_s2 = st_reg.rstn_s1;
      st_next.odt_s1 = termination_enable;
      st_next.odt_s2 = st_reg.odt_s1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      st_reg <= TOP_RESET;
    else
      st_reg <= st_next;
  end

  // outputs straight from the state register
  assign cmd_code = st_reg.code;
  assign cmd_strobe = st_reg.strobe;
  assign cmd_reject = st_reg.reject;
  assign access_bank = st_reg.bank;
  assign access_col = st_reg.col;
  assign access_full_burst = st_reg.full_burst;
  assign access_auto_precharge = st_reg.auto_pre;
  assign bank_open = st_reg.open;
  assign power_mode = st_reg.power;
  assign term_data_on = st_reg.term_data;
  assign term_strobe_on = st_reg.term_strobe;
  assign termination_strobe_mode = st_reg.strobe_mode;
  assign wr_data = st_reg.wdata;
  assign wr_keep = st_reg.keep;
  assign wr_strobe = st_reg.wvalid;
endmodule

// file: sdram_cmd_pkg.sv
// shared constants, command codes and crossing word of the command decoder
package sdram_cmd_pkg;
  localparam int BANK_W = 3;
  localparam int NUM_BANKS = 8;
  localparam int ADDR_W = 14;
  localparam int DATA_W = 8;
  localparam int COL_W = 10;
  localparam int MODE_TABLES = 4;
  localparam int MODE_SEL_W = 2;
  // address field positions
  localparam int PRE_FLAG_POS = 10;
  localparam int CHOP_POS = 12;
  // mode table zero: burst length field
  localparam int BURST_FIELD_LO = 0;
  localparam logic [1:0] BURST_FIXED8 = 2'h0;
  localparam logic [1:0] BURST_ON_FLY = 2'h1;
  localparam logic [1:0] BURST_FIXED4 = 2'h2;
  // mode table one: termination strobe enable and nominal termination bits
  localparam int TERM_STROBE_POS = 11;
  localparam int RTT_NOM_POS0 = 2;
  localparam int RTT_NOM_POS1 = 6;
  localparam int RTT_NOM_POS2 = 9;
  // mode table two: write termination field
  localparam int RTT_WR_LO = 9;
  localparam int RTT_WR_HI = 10;
  // table indexes chosen by the low bank select bits
  localparam logic [1:0] MODE_ZERO_SEL = 2'h0;
  localparam logic [1:0] MODE_ONE_SEL = 2'h1;
  localparam logic [1:0] MODE_TWO_SEL = 2'h2;
  localparam logic [ADDR_W-1:0] MODE_RESET = 14'h0000;
  localparam logic [NUM_BANKS-1:0] BANKS_IDLE = 8'h00;
  localparam logic [NUM_BANKS-1:0] BANKS_ALL = 8'hff;

  typedef enum logic [3:0] {
    CMD_NONE = 4'h0,
    CMD_NOP = 4'h1,
    CMD_DES = 4'h2,
    CMD_ACT = 4'h3,
    CMD_PRE = 4'h4,
    CMD_RD = 4'h5,
    CMD_WR = 4'h6,
    CMD_MRS = 4'h7,
    CMD_REF = 4'h8,
    CMD_SREF_IN = 4'h9,
    CMD_PDOWN_IN = 4'ha,
    CMD_LOW_EXIT = 4'hb,
    CMD_ZQ = 4'hc
  } cmd_t;

  typedef enum logic [2:0] {
    PWR_RUN = 3'h1,
    PWR_DOWN = 3'h2,
    PWR_SELF = 3'h4
  } power_t;

  typedef struct packed {
    cmd_t cmd;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
    logic [2*DATA_W-1:0] wdata;
    logic [1:0] keep;
    logic wvalid;
  } evt_t;

  localparam evt_t EVT_RESET = '{cmd: CMD_NONE, bank: 3'h0, addr: 14'h0000,
                                 wdata: 16'h0000, keep: 2'h0, wvalid: 1'b0};
endpackage

// file: sdram_evt_if.sv
// event word and level crossing between link and system clock domains
`timescale 1ns/100ps
interface sdram_evt_if;
  sdram_cmd_pkg::evt_t word;
  logic flip;
  logic mask_allow;
  modport src (output word, output flip, input mask_allow);
  modport dst (input word, input flip);
endinterface

// file: sdram_link_front.sv
// link clock side: pin sampling, command decode, write beat masking
`timescale 1ns/100ps
module sdram_link_front (
  input wire logic ck_link,
  input wire logic reset_n,
  input wire logic chip_select_n,
  input wire logic row_strobe_n,
  input wire logic col_strobe_n,
  input wire logic write_select_n,
  input wire logic clock_gate,
  input wire logic [sdram_cmd_pkg::BANK_W-1:0] bank_select,
  input wire logic [sdram_cmd_pkg::ADDR_W-1:0] addr,
  input wire logic [sdram_cmd_pkg::DATA_W-1:0] data_lines_rise,
  input wire logic [sdram_cmd_pkg::DATA_W-1:0] data_lines_fall,
  input wire logic write_byte_mask_rise,
  input wire logic write_byte_mask_fall,
  input wire logic data_beat_valid,
  sdram_evt_if.src evt
);
  typedef struct packed {
    logic gate_prev;
    logic mask_s1;
    logic mask_s2;
    logic flip;
    sdram_cmd_pkg::evt_t word;
  } link_state_t;

  localparam link_state_t LINK_RESET = '{gate_prev: 1'b0, mask_s1: 1'b0, mask_s2: 1'b0,
                                         flip: 1'b0, word: sdram_cmd_pkg::EVT_RESET};

  link_state_t st_reg;
  link_state_t st_next;
  sdram_cmd_pkg::cmd_t cmd;
  logic [1:0] keep;
  logic idle_code;

  // command decode from the strobes and both gating levels
  always_comb
  begin
    idle_code = chip_select_n || (row_strobe_n && col_strobe_n && write_select_n);
    cmd = sdram_cmd_pkg::CMD_NONE;
    if (st_reg.gate_prev && clock_gate)
    begin
      if (chip_select_n)
        cmd = sdram_cmd_pkg::CMD_DES; // RULE17
      else
      begin
        unique case ({row_strobe_n, col_strobe_n, write_select_n})
          3'b111: cmd = sdram_cmd_pkg::CMD_NOP;
          3'b011: cmd = sdram_cmd_pkg::CMD_ACT;
          3'b010: cmd = sdram_cmd_pkg::CMD_PRE;
          3'b101: cmd = sdram_cmd_pkg::CMD_RD; // RULE9
          3'b100: cmd = sdram_cmd_pkg::CMD_WR; // RULE8
          3'b000: cmd = sdram_cmd_pkg::CMD_MRS; // RULE12
          3'b001: cmd = sdram_cmd_pkg::CMD_REF; // RULE13
          3'b110: cmd = sdram_cmd_pkg::CMD_ZQ;
        endcase
      end
    end
    else if (st_reg.gate_prev && !clock_gate)
    begin
      if (!chip_select_n && {row_strobe_n, col_strobe_n, write_select_n} == 3'b001)
        cmd = sdram_cmd_pkg::CMD_SREF_IN; // RULE13
      else if (idle_code)
        cmd = sdram_cmd_pkg::CMD_PDOWN_IN; // RULE14
    end
    else if (!st_reg.gate_prev && clock_gate && idle_code)
      cmd = sdram_cmd_pkg::CMD_LOW_EXIT; // RULE15
  end

  // masked beats are dropped, unless masking is turned off
  always_comb
  begin
    keep[0] = data_beat_valid && !(write_byte_mask_rise && st_reg.mask_s2); // RULE1 RULE16
    keep[1] = data_beat_valid && !(write_byte_mask_fall && st_reg.mask_s2); // RULE1 RULE16
  end

  // next state: hold word stable and toggle once per new event
  always_comb
  begin
    st_next = st_reg;
    st_next.gate_prev = clock_gate;
    st_next.mask_s1 = evt.mask_allow;
    st_next.mask_s2 = st_reg.mask_s1;
    if ((cmd != sdram_cmd_pkg::CMD_NONE && cmd != sdram_cmd_pkg::CMD_NOP
        && cmd != sdram_cmd_pkg::CMD_DES) || data_beat_valid)
    begin
      st_next.word.cmd = cmd;
      st_next.word.bank = bank_select;
      st_next.word.addr = addr;
      st_next.word.wdata = {data_lines_fall, data_lines_rise}; // RULE2
      st_next.word.keep = keep;
      st_next.word.wvalid = data_beat_valid;
      st_next.flip = !st_reg.flip;
    end
  end

  // pin reset acts without the clock
  always_ff @(posedge ck_link or negedge reset_n)
  begin
    if (!reset_n)
      st_reg <= LINK_RESET; // RULE6
    else
      st_reg <= st_next;
  end

  assign evt.word = st_reg.word;
  assign evt.flip = st_reg.flip;
endmodule

// file: sdram_evt_sync.sv
// system clock side of the event crossing: toggle sync and word capture
`timescale 1ns/100ps
module sdram_evt_sync (
  input wire logic clk_sys,
  input wire logic rst,
  sdram_evt_if.dst evt,
  output sdram_cmd_pkg::evt_t evt_word,
  output logic evt_valid
);
  typedef struct packed {
    logic flip_s1;
    logic flip_s2;
    logic flip_s3;
    logic valid;
    sdram_cmd_pkg::evt_t word;
  } sync_state_t;

  localparam sync_state_t SYNC_RESET = '{flip_s1: 1'b0, flip_s2: 1'b0, flip_s3: 1'b0,
                                         valid: 1'b0, word: sdram_cmd_pkg::EVT_RESET};

  sync_state_t st_reg;
  sync_state_t st_next;

  // word is held a whole link period, so it is stable once the toggle lands
  always_comb
  begin
    st_next = st_reg;
    st_next.flip_s1 = evt.flip;
    st_next.flip_s2 = st_reg.flip_s1;
    st_next.flip_s3 = st_reg.flip_s2;
    st_next.valid = st_reg.flip_s2 != st_reg.flip_s3;
    if (st_reg.flip_s2 != st_reg.flip_s3)
      st_next.word = evt.word;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      st_reg <= SYNC_RESET;
    else
      st_reg <= st_next;
  end

  assign evt_word = st_reg.word;
  assign evt_valid = st_reg.valid;
endmodule

// file: sdram_command_decoder_asserts.sv
// concurrent checks on the command decoder top ports
`timescale 1ns/100ps
module sdram_command_decoder_asserts #(
  parameter int NUM_BANKS = sdram_cmd_pkg::NUM_BANKS
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic reset_n,
  input wire logic termination_enable,
  input sdram_cmd_pkg::cmd_t cmd_code,
  input wire logic cmd_strobe,
  input wire logic cmd_reject,
  input wire logic [sdram_cmd_pkg::BANK_W-1:0] access_bank,
  input wire logic access_auto_precharge,
  input wire logic [NUM_BANKS-1:0] bank_open,
  input sdram_cmd_pkg::power_t power_mode,
  input wire logic term_data_on,
  input wire logic term_strobe_on,
  input wire logic termination_strobe_mode
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // command outcome pulses and refusals
  a_pulse_excl: assert property (!(cmd_strobe && cmd_reject))
    else $error("strobe and reject together");
  a_reject_keeps_state: assert property (cmd_reject |-> $stable(bank_open) && $stable(power_mode))
    else $error("refused command changed state");
  a_autopre_close: assert property (cmd_strobe && cmd_code inside {sdram_cmd_pkg::CMD_RD,
    sdram_cmd_pkg::CMD_WR} |-> ##[0:1] bank_open[access_bank] != access_auto_precharge)
    else $error("bank state after access wrong");
  // power state transitions
  a_sref_idle: assert property ($changed(power_mode) && power_mode == sdram_cmd_pkg::PWR_SELF
    |-> bank_open == sdram_cmd_pkg::BANKS_IDLE) else $error("self refresh with open bank");
  a_pdown_entry: assert property (cmd_strobe && cmd_code == sdram_cmd_pkg::CMD_PDOWN_IN
    |-> ##[0:1] power_mode == sdram_cmd_pkg::PWR_DOWN) else $error("power down not entered");
  a_exit_run: assert property (cmd_strobe && cmd_code == sdram_cmd_pkg::CMD_LOW_EXIT
    |-> ##[0:1] power_mode == sdram_cmd_pkg::PWR_RUN) else $error("low power not left");
  a_power_onehot: assert property ($onehot(power_mode))
    else $error("power mode not one-hot");
  // termination control
  a_strobe_term: assert property (term_strobe_on |-> termination_strobe_mode && term_data_on)
    else $error("strobe termination off mode");
  a_term_idle: assert property (!termination_enable [*4] |=> !term_data_on)
    else $error("termination without enable");
  // pin reset clears state
  a_pin_reset: assert property (!reset_n [*3] |=> bank_open == sdram_cmd_pkg::BANKS_IDLE
    && power_mode == sdram_cmd_pkg::PWR_RUN) else $error("pin reset kept state");
endmodule
bind sdram_command_decoder sdram_command_decoder_asserts #(.NUM_BANKS(NUM_BANKS)) chk_u (
  .clk_sys, .srst, .reset_n, .termination_enable, .cmd_code, .cmd_strobe, .cmd_reject,
  .access_bank, .access_auto_precharge, .bank_open, .power_mode, .term_data_on,
  .term_strobe_on, .termination_strobe_mode);

// file: sdram_ctrl_model.sv
// controller side model driving command, address and write beats
`timescale 1ns/100ps
module sdram_ctrl_model (
  input wire logic ck_link,
  output logic reset_n,
  output logic [3:0] strobes_n,
  output logic clock_gate,
  output logic [2:0] bank_select,
  output logic [13:0] addr,
  output logic [15:0] beats,
  output logic [1:0] beat_mask,
  output logic beat_valid
);
  logic [7:0] open_banks;
  // idle pins, pin reset active until the bench releases it
  initial
  begin
    {reset_n, strobes_n, clock_gate, beat_valid} = 7'h3e;
    {bank_select, addr, beats, beat_mask} = '0;
    open_banks = 8'h00;
  end
  // whether the addressed bank state allows the command
  function automatic logic legal(input logic [3:0] c, input logic [2:0] b);
    case (c)
      4'h3: legal = !open_banks[b];
      4'h4, 4'h5: legal = open_banks[b];
      4'h0, 4'h1: legal = (open_banks == 8'h00);
      default: legal = 1'b1;
    endcase
  endfunction
  // one command cycle, mask high only on bytes to drop
  task automatic send(input logic [3:0] c, input logic g, input logic [2:0] b,
    input logic [13:0] a, input logic [15:0] d, input logic [1:0] m);
    @(posedge ck_link);
    #1;
    {strobes_n, clock_gate, bank_select, addr, beats, beat_mask} = {c, g, b, a, d, m};
    beat_valid = (c == 4'h4);
    if (legal(c, b) && g)
    begin
      case (c)
        4'h3: open_banks[b] = 1'b1;
        4'h2: open_banks = a[10] ? 8'h00 : open_banks & ~(8'h01 << b);
        4'h4, 4'h5: if (a[10]) open_banks[b] = 1'b0;
        default: ;
      endcase
    end
    @(posedge ck_link);
    #1;
    // released strobes give a NOP, the other released lines show the inverse
    {strobes_n, bank_select, addr, beats, beat_mask} = {4'h7, ~b, ~a, ~d, ~m};
    beat_valid = 1'b0;
  endtask
  // pin reset pulse over two link cycles
  task automatic pulse_reset();
    reset_n = 1'b0;
    open_banks = 8'h00;
    repeat (2) @(posedge ck_link);
    #1;
    reset_n = 1'b1;
  endtask
endmodule

// file: sdram_command_decoder_test.sv
// self-checking bench of the command decoder
`timescale 1ns/100ps
`define CHK(nm, got, exp) begin compares++; if ((got) !== (exp)) begin bad_count++; \
  $display("mismatch %s expected %0h seen %0h", nm, exp, got); end end
module sdram_command_decoder_test;
  logic clk_sys = 1'b0;
  logic ck_link = 1'b0;
  logic srst = 1'b1;
  logic termination_enable = 1'b0;
  logic reset_n, clock_gate, beat_valid;
  logic [3:0] strobes_n;
  logic [2:0] bank_select, access_bank;
  logic [13:0] addr;
  logic [15:0] beats, wr_data;
  logic [1:0] beat_mask, wr_keep;
  logic cmd_strobe, cmd_reject, access_full_burst, access_auto_precharge, wr_strobe;
  logic term_data_on, term_strobe_on, termination_strobe_mode;
  logic [9:0] access_col;
  logic [7:0] bank_open;
  sdram_cmd_pkg::cmd_t cmd_code;
  sdram_cmd_pkg::power_t power_mode;
  int bad_count = 0;
  int compares = 0;
  int seed = 32'hd826;
  logic [1:0] burst_mode = 2'h0;
  logic strobe_mode = 1'b0;
  always #4 clk_sys = ~clk_sys;
  // link clock, free phase
  initial
  begin
    #3;
    forever #32 ck_link = ~ck_link;
  end
  sdram_ctrl_model mdl_u (.ck_link, .reset_n, .strobes_n, .clock_gate, .bank_select, .addr,
    .beats, .beat_mask, .beat_valid);
  sdram_command_decoder dut_u (.clk_sys, .srst, .ck_link, .reset_n,
    .chip_select_n(strobes_n[3]), .row_strobe_n(strobes_n[2]), .col_strobe_n(strobes_n[1]),
    .write_select_n(strobes_n[0]), .clock_gate, .bank_select, .addr, .termination_enable,
    .data_lines_rise(beats[7:0]), .data_lines_fall(beats[15:8]),
    .write_byte_mask_rise(beat_mask[0]), .write_byte_mask_fall(beat_mask[1]),
    .data_beat_valid(beat_valid), .cmd_code, .cmd_strobe, .cmd_reject, .access_bank,
    .access_col, .access_full_burst, .access_auto_precharge, .bank_open, .power_mode,
    .term_data_on, .term_strobe_on, .termination_strobe_mode, .wr_data, .wr_keep, .wr_strobe);
  // expected burst length and kept beats
  function automatic logic exp_full(input logic [13:0] a);
    exp_full = (burst_mode == sdram_cmd_pkg::BURST_ON_FLY) ? a[sdram_cmd_pkg::CHOP_POS]
        : (burst_mode != sdram_cmd_pkg::BURST_FIXED4);
  endfunction
  function automatic logic [1:0] exp_keep(input logic [1:0] m);
    exp_keep = strobe_mode ? 2'h3 : ~m;
  endfunction
  task automatic report_and_stop();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // one command through the model, then its outcome at the system side
  task automatic run(input logic [3:0] c, input logic g, input logic [2:0] b,
    input logic [13:0] a, input sdram_cmd_pkg::cmd_t ec);
    logic ok;
    logic [15:0] d;
    logic [1:0] m;
    int i;
    d = $random(seed);
    m = $random(seed);
    ok = mdl_u.legal(c, b);
    mdl_u.send(c, g, b, a, d, m);
    for (i = 0; i < 12 && cmd_strobe !== 1'b1 && cmd_reject !== 1'b1; i++)
      @(posedge clk_sys) #1;
    `CHK("event", cmd_strobe | cmd_reject, ec != sdram_cmd_pkg::CMD_NONE)
    if (i == 12 && ec != sdram_cmd_pkg::CMD_NONE)
      report_and_stop();
    if (ec != sdram_cmd_pkg::CMD_NONE)
    begin
      `CHK("code", cmd_code, ec)
      `CHK("accept", cmd_strobe, ok)
    end
    if (ok && (c == 4'h4 || c == 4'h5))
    begin
      `CHK("col", access_col, a[9:0])
      `CHK("full", access_full_burst, exp_full(a))
      `CHK("autopre", access_auto_precharge, a[10])
    end
    if (ok && c == 4'h4)
    begin
      `CHK("wstrobe", {wr_strobe, wr_data}, {1'b1, d})
      `CHK("keep", wr_keep, exp_keep(m))
    end
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK("banks", bank_open, mdl_u.open_banks)
  endtask
  // close all banks, then load a mode table
  task automatic mrs(input logic [1:0] sel, input logic [13:0] op);
    run(4'h2, 1'b1, 3'h0, 14'h0400, sdram_cmd_pkg::CMD_PRE);
    run(4'h0, 1'b1, {1'b0, sel}, op, sdram_cmd_pkg::CMD_MRS);
    if (sel == sdram_cmd_pkg::MODE_ZERO_SEL)
      burst_mode = op[1:0];
    if (sel == sdram_cmd_pkg::MODE_ONE_SEL)
      strobe_mode = op[sdram_cmd_pkg::TERM_STROBE_POS];
    repeat (3) @(posedge ck_link);
  endtask
  // main sequence
  initial
  begin
    logic [2:0] b;
    logic [13:0] a;
    mdl_u.pulse_reset();
    repeat (6) @(posedge clk_sys);
    #1;
    srst = 1'b0;
    repeat (3) @(posedge ck_link);
    // random traffic under fixed eight, on the fly and fixed four
    for (int k = 0; k < 12; k++)
    begin
      b = $random(seed);
      a = $random(seed);
      if (k % 4 == 0)
        mrs(2'h0, {12'h000, k[3:2]});
      run(4'h3, 1'b1, b, a, sdram_cmd_pkg::CMD_ACT);
      run(4'h3, 1'b1, b, a, sdram_cmd_pkg::CMD_ACT);
      run(4'h4, 1'b1, b, a, sdram_cmd_pkg::CMD_WR);
      run(4'h5, 1'b1, b, ~a, sdram_cmd_pkg::CMD_RD);
      run(4'h2, 1'b1, ~b, a, sdram_cmd_pkg::CMD_PRE);
    end
    // deselect hides a write pattern, then low power entry and exit
    run(4'hc, 1'b1, 3'h0, 14'h0000, sdram_cmd_pkg::CMD_NONE);
    run(4'h2, 1'b1, 3'h0, 14'h0400, sdram_cmd_pkg::CMD_PRE);
    run(4'h1, 1'b1, 3'h0, 14'h0000, sdram_cmd_pkg::CMD_REF);
    run(4'h6, 1'b1, 3'h0, 14'h0000, sdram_cmd_pkg::CMD_ZQ);
    run(4'h1, 1'b0, 3'h0, 14'h0000, sdram_cmd_pkg::CMD_SREF_IN);
    `CHK("self", power_mode, sdram_cmd_pkg::PWR_SELF)
    run(4'h7, 1'b1, 3'h0, 14'h0000, sdram_cmd_pkg::CMD_LOW_EXIT);
    run(4'h7, 1'b0, 3'h0, 14'h0000, sdram_cmd_pkg::CMD_PDOWN_IN);
    `CHK("pdown", power_mode, sdram_cmd_pkg::PWR_DOWN)
    run(4'h7, 1'b1, 3'h0, 14'h0000, sdram_cmd_pkg::CMD_LOW_EXIT);
    `CHK("run", power_mode, sdram_cmd_pkg::PWR_RUN)
    // termination ignored, applied, then strobe mode disables masking
    termination_enable = 1'b1;
    mrs(2'h1, 14'h0000);
    `CHK("term off", term_data_on, 1'b0)
    mrs(2'h1, 14'h0804);
    `CHK("term on", term_data_on, 1'b1)
    `CHK("strobe", {termination_strobe_mode, term_strobe_on}, 2'h3)
    run(4'h3, 1'b1, 3'h5, 14'h0000, sdram_cmd_pkg::CMD_ACT);
    run(4'h4, 1'b1, 3'h5, 14'h1000, sdram_cmd_pkg::CMD_WR);
    // pin reset mid-run closes the open bank
    mdl_u.pulse_reset();
    repeat (6) @(posedge clk_sys);
    `CHK("reset", bank_open, sdram_cmd_pkg::BANKS_IDLE)
    report_and_stop();
  end
endmodule
